/* core/sel_pkg.sv */
package sel_pkg;
  // selection code width and the documented function codes
  localparam int unsigned CODE_W = 7;
  localparam logic [CODE_W-1:0] CODE_ZERO_RUN   = 7'h21; // 33
  localparam logic [CODE_W-1:0] CODE_ZERO_STOP  = 7'h22; // 34
  localparam logic [CODE_W-1:0] CODE_ERR_FIRST  = 7'h23; // 35
  localparam logic [CODE_W-1:0] CODE_ERR_LAST   = 7'h26; // 38
  localparam logic [CODE_W-1:0] CODE_SPEED_REACH = 7'h28; // 40
  localparam logic [CODE_W-1:0] CODE_SPEED_LOW  = 7'h2b; // 43
  localparam logic [CODE_W-1:0] CODE_VALVE      = 7'h2d; // 45
  localparam logic [CODE_W-1:0] CODE_DIP_DECEL  = 7'h2e; // 46
  localparam logic [CODE_W-1:0] CODE_COMM       = 7'h33; // 51
  localparam logic [CODE_W-1:0] CODE_FIRE       = 7'h35; // 53
  localparam logic [CODE_W-1:0] CODE_ANALOG     = 7'h43; // 67
  localparam logic [CODE_W-1:0] CODE_PREHEAT    = 7'h45; // 69
  localparam logic [CODE_W-1:0] CODE_FWD_RUN    = 7'h4b; // 75

  // terminals and their polarity bit positions
  localparam int unsigned NUM_TERM  = 2;
  localparam int unsigned TERM_RELAY = 0;
  localparam int unsigned TERM_FIRST_OUT = 1;
  localparam int unsigned POL_W      = 16;
  localparam int unsigned POL_BIT_RELAY = 0;
  localparam int unsigned POL_BIT_FIRST_OUT = 3;

  // analog window, levels in percent
  localparam int unsigned PCT_W = 8;
  localparam logic [PCT_W-1:0] ANA_HIGH_RST = 8'h32; // 50 %
  localparam logic [PCT_W-1:0] ANA_LOW_RST  = 8'h0a; // 10 %
  localparam logic ANA_SEL_VOLT = 1'b0;
  localparam logic ANA_SEL_CURR = 1'b1;

  localparam int unsigned SPD_W = 16;
  localparam int unsigned ERR_N = 4;
endpackage : sel_pkg

/* core/ana_win_if.sv */
`timescale 1ns/1ps
// analog level and thresholds toward the window comparator
interface ana_win_if;
  import sel_pkg::*;
  logic [PCT_W-1:0] level;
  logic [PCT_W-1:0] high;
  logic [PCT_W-1:0] low;
  logic             active;
  modport ctrl (output level, output high, output low, input active);
  modport win  (input level, input high, input low, output active);
endinterface : ana_win_if

/* core/analog_window.sv */
`timescale 1ns/1ps
module analog_window (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // comparator port
  ana_win_if.win    aw
);
  import sel_pkg::*;

  logic act_q;
  logic act_d;

  // hysteresis: set above high, clear below low, else hold
  always_comb begin
    act_d = act_q;
    if (aw.level > aw.high) begin
      act_d = 1'b1;
    end else if (aw.level < aw.low) begin
      act_d = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= 1'b0;
    end else begin
      act_q <= act_d;
    end
  end

  assign aw.active = act_q;

  a_win_sets_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (aw.level > aw.high) |=> act_q)
    else $error("window did not turn on above high level");
  a_win_clears_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (aw.level < aw.low && aw.level <= aw.high) |=> !act_q)
    else $error("window did not turn off below low level");
  a_win_holds_mid: assert property (@(posedge clk_i) disable iff (rst_i)
    (aw.level <= aw.high && aw.level >= aw.low) |=> $stable(act_q))
    else $error("window changed between thresholds");
endmodule : analog_window

/* core/status_output_selector.sv */
`timescale 1ns/1ps
// Contract
// - code 33 asserts while the output frequency is zero and the drive runs.
// - code 34 asserts while the output frequency is zero or the drive stops.
// - codes 35 to 38 follow error-selection flags 1 to 4 in order.
// - code 40 asserts at speed reached and also while the drive is stopped.
// - code 43 asserts with pulse speed input in use and speed below limit.
// - code 46 on the first digital output follows power-dip deceleration.
// - code 51 drives the terminal from the RS-485 command level, inverted by its polarity bit.
// - code 53 asserts while either fire-mode input function is active.
// - code 67 sets above high, clears below low and holds in between.
// - the window uses a chosen channel, thresholds resetting to 50 and 10.
// - code 69 asserts while motor preheating is enabled.
// - code 75 closes while running forward and opens when stopped.
// - code 45 drives the valve contactor from the enable input and status.
// - a polarity bit of one inverts the terminal to normally closed; a code with no function on the terminal keeps it open.
module status_output_selector (
  // clock and reset
  input  wire logic                        MCLK_I,
  input  wire logic                        RST_I,
  // terminal configuration
  input  wire logic [sel_pkg::CODE_W-1:0]  RELAY_CODE_I,
  input  wire logic [sel_pkg::CODE_W-1:0]  FIRST_OUT_CODE_I,
  input  wire logic [sel_pkg::POL_W-1:0]   OUTPUT_POLARITY_BITS_I,
  // drive status
  input  wire logic                        FREQ_ZERO_I,
  input  wire logic                        RUNNING_I,
  input  wire logic                        FORWARD_I,
  input  wire logic                        SPEED_REACHED_I,
  input  wire logic [sel_pkg::ERR_N-1:0]   ERROR_SELECT_FLAG_I,
  input  wire logic                        POWER_DIP_DECEL_I,
  input  wire logic                        PREHEAT_EN_I,
  input  wire logic                        DRIVE_ENABLE_IN_I,
  input  wire logic                        FIRE_MODE_A_I,
  input  wire logic                        FIRE_MODE_B_I,
  // speed detection
  input  wire logic                        PULSE_SPEED_INPUT_I,
  input  wire logic [sel_pkg::SPD_W-1:0]   MOTOR_SPEED_I,
  input  wire logic [sel_pkg::SPD_W-1:0]   SPEED_LOW_THRESHOLD_I,
  // communication commanded levels, one per terminal
  input  wire logic [sel_pkg::NUM_TERM-1:0] COMM_LEVEL_I,
  // analog window
  input  wire logic [sel_pkg::PCT_W-1:0]   VOLTAGE_ANALOG_CHANNEL_I,
  input  wire logic [sel_pkg::PCT_W-1:0]   CURRENT_ANALOG_CHANNEL_I,
  input  wire logic                        ANA_CFG_WE_I,
  input  wire logic                        ANALOG_CHANNEL_SELECT_I,
  input  wire logic [sel_pkg::PCT_W-1:0]   ANALOG_HIGH_THRESHOLD_I,
  input  wire logic [sel_pkg::PCT_W-1:0]   ANALOG_LOW_THRESHOLD_I,
  // terminals and status
  output logic                             RELAY_OUTPUT_ONE_O,
  output logic                             FIRST_DIGITAL_OUTPUT_O,
  output logic                             ANALOG_WINDOW_O
);
  import sel_pkg::*;

  ana_win_if aw ();

  logic [PCT_W-1:0]    high_q;
  logic [PCT_W-1:0]    high_d;
  logic [PCT_W-1:0]    low_q;
  logic [PCT_W-1:0]    low_d;
  logic                chan_q;
  logic                chan_d;
  logic [NUM_TERM-1:0] term_q;
  logic [NUM_TERM-1:0] term_d;
  logic                win_q;
  logic                win_d;
  logic [CODE_W-1:0]   codes [NUM_TERM];
  logic [NUM_TERM-1:0] pol;

  // selected condition; valid is low for codes with no function here
  function automatic logic [1:0] sel_cond(input logic [CODE_W-1:0] code,
                                          input logic             is_first,
                                          input logic             comm);
    logic c;
    logic v;
    c = 1'b0;
    v = 1'b1;
    if (code == CODE_ZERO_RUN) begin
      c = FREQ_ZERO_I && RUNNING_I;
    end else if (code == CODE_ZERO_STOP) begin
      c = FREQ_ZERO_I || !RUNNING_I;
    end else if (code >= CODE_ERR_FIRST && code <= CODE_ERR_LAST) begin
      c = ERROR_SELECT_FLAG_I[2'(code - CODE_ERR_FIRST)];
    end else if (code == CODE_SPEED_REACH) begin
      c = SPEED_REACHED_I || !RUNNING_I;
    end else if (code == CODE_SPEED_LOW) begin
      c = PULSE_SPEED_INPUT_I
          && (MOTOR_SPEED_I < SPEED_LOW_THRESHOLD_I);
    end else if (code == CODE_VALVE) begin
      c = DRIVE_ENABLE_IN_I && RUNNING_I;
    end else if (code == CODE_DIP_DECEL && is_first) begin
      c = POWER_DIP_DECEL_I;
    end else if (code == CODE_COMM) begin
      c = comm;
    end else if (code == CODE_FIRE) begin
      c = FIRE_MODE_A_I || FIRE_MODE_B_I;
    end else if (code == CODE_ANALOG) begin
      c = aw.active;
    end else if (code == CODE_PREHEAT) begin
      c = PREHEAT_EN_I;
    end else if (code == CODE_FWD_RUN) begin
      c = RUNNING_I && FORWARD_I;
    end else begin
      v = 1'b0;
    end
    sel_cond = {v, c};
  endfunction : sel_cond

  // analog window configuration and channel choice
  always_comb begin
    high_d = high_q;
    low_d  = low_q;
    chan_d = chan_q;
    if (ANA_CFG_WE_I) begin
      high_d = ANALOG_HIGH_THRESHOLD_I;
      low_d  = ANALOG_LOW_THRESHOLD_I;
      chan_d = ANALOG_CHANNEL_SELECT_I;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      high_q <= ANA_HIGH_RST;
      low_q  <= ANA_LOW_RST;
      chan_q <= ANA_SEL_VOLT;
    end else begin
      high_q <= high_d;
      low_q  <= low_d;
      chan_q <= chan_d;
    end
  end

  // comparator feed
  assign aw.level = (chan_q == ANA_SEL_CURR) ? CURRENT_ANALOG_CHANNEL_I
                                             : VOLTAGE_ANALOG_CHANNEL_I;
  assign aw.high  = high_q;
  assign aw.low   = low_q;

  analog_window u_win (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .aw    (aw.win)
  );

  // per-terminal code and polarity
  assign codes[TERM_RELAY] = RELAY_CODE_I;
  assign codes[TERM_FIRST_OUT] = FIRST_OUT_CODE_I;
  assign pol[TERM_RELAY]   = OUTPUT_POLARITY_BITS_I[POL_BIT_RELAY];
  assign pol[TERM_FIRST_OUT] = OUTPUT_POLARITY_BITS_I[POL_BIT_FIRST_OUT];

  // terminal next values
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    logic [1:0] vc;
    // a process, so status read inside the function also wakes it
    always_comb begin
      vc = sel_cond(codes[t], t == TERM_FIRST_OUT, COMM_LEVEL_I[t]);
    end
    assign term_d[t] = vc[1] && (vc[0] ^ pol[t]);
  end

  assign win_d = aw.active;

  // output registers
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      term_q <= '0;
      win_q  <= 1'b0;
    end else begin
      term_q <= term_d;
      win_q  <= win_d;
    end
  end

  assign RELAY_OUTPUT_ONE_O     = term_q[TERM_RELAY];
  assign FIRST_DIGITAL_OUTPUT_O = term_q[TERM_FIRST_OUT];
  assign ANALOG_WINDOW_O        = win_q;

  a_zero_run_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == CODE_ZERO_RUN && !OUTPUT_POLARITY_BITS_I[POL_BIT_RELAY])
    |=> RELAY_OUTPUT_ONE_O == $past(FREQ_ZERO_I && RUNNING_I))
    else $error("zero speed in run mismatch");
  a_zero_stop_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == CODE_ZERO_STOP && !OUTPUT_POLARITY_BITS_I[POL_BIT_RELAY])
    |=> RELAY_OUTPUT_ONE_O == $past(FREQ_ZERO_I || !RUNNING_I))
    else $error("zero speed or stop mismatch");
  a_err_flag_map: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (FIRST_OUT_CODE_I == CODE_ERR_LAST
     && !OUTPUT_POLARITY_BITS_I[POL_BIT_FIRST_OUT])
    |=> FIRST_DIGITAL_OUTPUT_O == $past(ERROR_SELECT_FLAG_I[ERR_N-1]))
    else $error("error flag four not mirrored");
  a_speed_reach_stop: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == CODE_SPEED_REACH && !RUNNING_I
     && !OUTPUT_POLARITY_BITS_I[POL_BIT_RELAY]) |=> RELAY_OUTPUT_ONE_O)
    else $error("speed reached not on while stopped");
  a_dip_relay_off: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == CODE_DIP_DECEL) |=> !RELAY_OUTPUT_ONE_O)
    else $error("power dip signal on relay terminal");
  a_dip_first_follow: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (FIRST_OUT_CODE_I == CODE_DIP_DECEL
     && !OUTPUT_POLARITY_BITS_I[POL_BIT_FIRST_OUT])
    |=> FIRST_DIGITAL_OUTPUT_O == $past(POWER_DIP_DECEL_I))
    else $error("power dip not on first digital output");
  a_comm_level_pol: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (FIRST_OUT_CODE_I == CODE_COMM) |=> FIRST_DIGITAL_OUTPUT_O ==
    $past(COMM_LEVEL_I[TERM_FIRST_OUT]
          ^ OUTPUT_POLARITY_BITS_I[POL_BIT_FIRST_OUT]))
    else $error("communication level or polarity wrong");
  a_fwd_run_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == CODE_FWD_RUN && OUTPUT_POLARITY_BITS_I[POL_BIT_RELAY])
    |=> RELAY_OUTPUT_ONE_O == $past(!(RUNNING_I && FORWARD_I)))
    else $error("inverted forward run mismatch");
  a_undef_code_off: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (RELAY_CODE_I == 7'h27) |=> !RELAY_OUTPUT_ONE_O)
    else $error("undefined code drove relay");
endmodule : status_output_selector

/* testbench/slave_drive_model.sv */
`timescale 1ns/1ps
// slave drive input fed by the master's first digital output
module slave_drive_model (
  // clock and terminal
  input  wire logic clk_i,
  input  wire logic dip_in_i,
  // slave state
  output logic      slave_dip_o
);
  // slave joins the dip deceleration while the signal is on
  always_ff @(posedge clk_i) begin
    slave_dip_o <= dip_in_i;
  end
endmodule : slave_drive_model

/* testbench/test_status_output_selector.sv */
`timescale 1ns/1ps
module test_status_output_selector;
  import sel_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [CODE_W-1:0]   rc, dc;
  logic [POL_W-1:0]    pol;
  logic                fz, run, fwd, rch, dip, pre, en, fa, fb, pls;
  logic [ERR_N-1:0]    flg;
  logic [SPD_W-1:0]    spd, thr;
  logic [NUM_TERM-1:0] comm;
  logic [PCT_W-1:0]    av, ac, hi, lo, wh, wl;
  logic                we, sel, wsel, relay, fdo, win, slave, w;
  int                  bad_count, compares, i;
  logic [CODE_W-1:0]   codes [17] = '{7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
    7'h26, 7'h28, 7'h2b, 7'h2d, 7'h2e, 7'h33, 7'h35, 7'h45, 7'h4b,
    7'h00, 7'h27, 7'h7f};

  // free-running system clock
  always #4 clk = ~clk;

  status_output_selector i_status_output_selector (
    .MCLK_I(clk), .RST_I(rst), .RELAY_CODE_I(rc), .FIRST_OUT_CODE_I(dc),
    .OUTPUT_POLARITY_BITS_I(pol), .FREQ_ZERO_I(fz), .RUNNING_I(run),
    .FORWARD_I(fwd), .SPEED_REACHED_I(rch), .ERROR_SELECT_FLAG_I(flg),
    .POWER_DIP_DECEL_I(dip), .PREHEAT_EN_I(pre), .DRIVE_ENABLE_IN_I(en),
    .FIRE_MODE_A_I(fa), .FIRE_MODE_B_I(fb), .PULSE_SPEED_INPUT_I(pls),
    .MOTOR_SPEED_I(spd), .SPEED_LOW_THRESHOLD_I(thr), .COMM_LEVEL_I(comm),
    .VOLTAGE_ANALOG_CHANNEL_I(av), .CURRENT_ANALOG_CHANNEL_I(ac),
    .ANA_CFG_WE_I(we), .ANALOG_CHANNEL_SELECT_I(sel),
    .ANALOG_HIGH_THRESHOLD_I(hi), .ANALOG_LOW_THRESHOLD_I(lo),
    .RELAY_OUTPUT_ONE_O(relay), .FIRST_DIGITAL_OUTPUT_O(fdo),
    .ANALOG_WINDOW_O(win));

  slave_drive_model i_slave_drive_model (
    .clk_i(clk), .dip_in_i(fdo), .slave_dip_o(slave));

  // expected terminal level for one code and polarity
  function automatic logic exp_term(logic [CODE_W-1:0] c, logic d,
                                    logic p);
    logic v;
    case (c)
      CODE_ZERO_RUN:    v = fz & run;
      CODE_ZERO_STOP:   v = fz | ~run;
      CODE_ERR_FIRST, 7'h24, 7'h25, CODE_ERR_LAST:
        v = flg[2'(c - CODE_ERR_FIRST)];
      CODE_SPEED_REACH: v = rch | ~run;
      CODE_SPEED_LOW:   v = pls & (spd < thr);
      CODE_VALVE:       v = en & run;
      CODE_DIP_DECEL:   if (d) v = dip; else return 1'b0;
      CODE_COMM:        v = comm[d];
      CODE_FIRE:        v = fa | fb;
      CODE_PREHEAT:     v = pre;
      CODE_FWD_RUN:     v = run & fwd;
      default:          return 1'b0;
    endcase
    return v ^ p;
  endfunction : exp_term

  task automatic check(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check

  task automatic finish_test;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // random drive status and terminal setup
  task automatic rnd;
    rc <= codes[$urandom % 17];
    dc <= codes[$urandom % 17];
    pol <= 16'($urandom);
    {fz, run, fwd, rch, dip, pre, en, fa, fb, pls} <= 10'($urandom);
    flg <= 4'($urandom);
    spd <= 16'($urandom % 64);
    thr <= 16'($urandom % 64);
    comm <= 2'($urandom);
  endtask : rnd

  // apply analog levels and compare the window after it settles
  task automatic ana(input logic [PCT_W-1:0] v, input logic [PCT_W-1:0] c);
    logic [PCT_W-1:0] l;
    @(posedge clk);
    av <= v;
    ac <= c;
    l = wsel ? c : v;
    w = (l > wh) ? 1'b1 : ((l < wl) ? 1'b0 : w);
    repeat (3) @(posedge clk);
    #1;
    check(win, w, "analog window state");
    check(relay, w, "analog level terminal");
  endtask : ana

  // hang guard
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h1f3c));
    {rc, dc, pol, fz, run, fwd, rch, dip, pre, en, fa, fb, pls} = '0;
    {flg, spd, thr, comm, av, ac, hi, lo, we, sel} = '0;
    wh = ANA_HIGH_RST;
    wl = ANA_LOW_RST;
    wsel = ANA_SEL_VOLT;
    w = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(relay | fdo | win, 1'b0, "outputs during reset");
    @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      rnd();
      @(posedge clk);
      #1;
      check(relay, exp_term(rc, 1'b0, pol[POL_BIT_RELAY]), "relay");
      check(fdo, exp_term(dc, 1'b1, pol[POL_BIT_FIRST_OUT]), "fdo");
      if (dc == CODE_DIP_DECEL && !pol[POL_BIT_FIRST_OUT]) begin
        @(posedge clk);
        #1;
        check(slave, dip, "slave dip follow");
      end
    end
    @(posedge clk);
    rc <= CODE_ANALOG;
    pol <= '0;
    ana(8'h33, 8'h00);
    ana(8'h32, 8'h00);
    ana(8'h0a, 8'h00);
    ana(8'h09, 8'h00);
    @(posedge clk);
    we <= 1'b1;
    sel <= ANA_SEL_CURR;
    hi <= 8'h3c;
    lo <= 8'h14;
    @(posedge clk);
    we <= 1'b0;
    {wsel, wh, wl} = {ANA_SEL_CURR, 8'h3c, 8'h14};
    ana(8'h63, 8'h3c);
    ana(8'h00, 8'h3d);
    ana(8'h00, 8'h14);
    ana(8'h63, 8'h13);
    ana(8'h00, 8'h3d);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    check(relay | win, 1'b0, "outputs in second reset");
    @(posedge clk);
    rst <= 1'b0;
    {wsel, wh, wl, w} = {ANA_SEL_VOLT, ANA_HIGH_RST, ANA_LOW_RST, 1'b0};
    ana(8'h37, 8'h00);
    finish_test();
  end
endmodule : test_status_output_selector
